// File: ctimc_map.svh
// Register map, field positions, reset values and sizes for the TLB selector and
// multithreading control block. Definitions only; included by bare name.
`ifndef CTIMC_MAP_SVH
`define CTIMC_MAP_SVH
`define CTIMC_SEL_IDX 3'h0
`define CTIMC_SEL_CTRL 3'h1
`define CTIMC_ENTRY_W 6
`define CTIMC_PROBE_BIT 31
`define CTIMC_CPA_BIT 3
`define CTIMC_SHARED_TLB_BIT_BIT 2
`define CTIMC_VPC_BIT 1
`define CTIMC_EVP_BIT 0
`define CTIMC_NUM_PE 2
`define CTIMC_PE_W 1
`define CTIMC_TC_W 4
`define CTIMC_RESET_TC 4'h0
`define CTIMC_SIZE_W 6
`define CTIMC_PER_PE_SIZE 6'h0F
`define CTIMC_SHARED_SIZE 6'h1F
`define CTIMC_TLB_ENTRIES 7'h20
`endif

// File: ctimc_pkg.sv
// Types shared by the selector and control logic.
// Assumes ctimc_map.svh is on the include path.
`include "ctimc_map.svh"
package ctimc_pkg;
	typedef logic [`CTIMC_ENTRY_W-1:0] ctimc_entry_t;
	typedef struct packed {
		logic probe_fail;
		ctimc_entry_t entry;
	} ctimc_sel_t;
	typedef enum logic [1:0] {
		CTIMC_RUN_SINGLE = 2'b00,
		CTIMC_RUN_MULTI = 2'b01,
		CTIMC_RUN_CONFIG = 2'b10
	} ctimc_run_t;
endpackage : ctimc_pkg

// File: ctimc_selector.sv
// One processing element's TLB selector register.
// Assumes probe results and moves come from the core pipeline, one per cycle.
`timescale 1ns/1ns
module ctimc_selector
	import ctimc_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic wr_en_in,
	input wire logic [31:0] wr_data_in,
	input wire logic probe_done_in,
	input wire logic probe_hit_in,
	input wire ctimc_entry_t probe_entry_in,
	output logic [31:0] rd_data_out,
	output logic probe_fail_out,
	output ctimc_entry_t entry_out
);
	ctimc_sel_t st;
	ctimc_sel_t next_st;

	// Probe wins over a move in the same cycle for the fail bit, and for the entry only on a hit; pipeline orders them anyway
	always_comb begin
		next_st = st;
		if (wr_en_in) begin
			next_st.entry = wr_data_in[`CTIMC_ENTRY_W-1:0];
			next_st.probe_fail = wr_data_in[`CTIMC_PROBE_BIT];
		end
		if (probe_done_in) begin
			next_st.probe_fail = ~probe_hit_in;
			if (probe_hit_in) begin
				next_st.entry = probe_entry_in;
			end
		end
	end

	// Reset value is undefined in the architecture; zero chosen for determinism
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// Bits 30:6 always read zero
	assign rd_data_out = {st.probe_fail, 25'h0000000, st.entry};
	assign probe_fail_out = st.probe_fail;
	assign entry_out = st.entry;
endmodule : ctimc_selector

// File: ctimc_top.sv
// Coprocessor-0 TLB selectors and processor-wide multithreading control.
// Assumes moves arrive from privileged instructions already decoded to a select
// and element number; the TLB array, random generator and scheduler sit outside.
`timescale 1ns/1ns
module ctimc_top
	import ctimc_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic coprocessor_move_to_instruction_in,
	input wire logic [2:0] sel_in,
	input wire logic [`CTIMC_PE_W-1:0] pe_in,
	input wire logic [31:0] wr_data_in,
	input wire logic master_privilege_bit_in,
	input wire logic [2:0] rd_sel_in,
	input wire logic [`CTIMC_PE_W-1:0] rd_pe_in,
	input wire logic enable_elements_instruction_in,
	input wire logic disable_elements_instruction_in,
	input wire logic [`CTIMC_TC_W-1:0] issuing_tc_in,
	input wire logic [`CTIMC_NUM_PE-1:0] probe_done_in,
	input wire logic [`CTIMC_NUM_PE-1:0] probe_hit_in,
	input wire logic [`CTIMC_NUM_PE*`CTIMC_ENTRY_W-1:0] probe_entry_in,
	input wire logic [`CTIMC_NUM_PE-1:0] pe_uses_tlb_in,
	input wire logic [`CTIMC_ENTRY_W-1:0] random_cand_in,
	input wire logic [`CTIMC_PE_W-1:0] random_pe_in,
	output logic [31:0] rd_data_out,
	output logic cache_partition_active_out,
	output logic shared_tlb_bit_out,
	output logic configuration_state_bit_out,
	output logic virtual_processor_enable_out,
	output logic [`CTIMC_NUM_PE-1:0] shared_tlb_pe_out,
	output logic [`CTIMC_NUM_PE*`CTIMC_SIZE_W-1:0] tlb_size_field_out,
	output logic random_skip_out,
	output logic scheduling_allowed_out,
	output logic [`CTIMC_TC_W-1:0] sole_tc_out,
	output logic presets_writable_out,
	output ctimc_run_t run_mode_out
);
	typedef struct packed {
		logic cache_partition_active;
		logic shared_tlb_bit;
		logic configuration_state_bit;
		logic virtual_processor_enable;
		logic [`CTIMC_TC_W-1:0] sole_tc;
		logic [31:0] rd_data;
		logic skip;
	} ctimc_state_t;

	ctimc_state_t st;
	ctimc_state_t next_st;
	logic [`CTIMC_NUM_PE-1:0][31:0] sel_rd;
	logic [`CTIMC_NUM_PE-1:0] sel_fail;
	logic [`CTIMC_NUM_PE-1:0][`CTIMC_ENTRY_W-1:0] sel_entry;
	logic [`CTIMC_NUM_PE-1:0] sel_wr;
	logic [`CTIMC_NUM_PE-1:0] sel_hit;
	logic ctrl_wr;
	logic [31:0] ctrl_word;

	// One selector per processing element
	genvar g;
	generate
		for (g = 0; g < `CTIMC_NUM_PE; g++) begin : g_pe
			// Element number widened to int so the genvar needs no slicing
			assign sel_wr[g] = coprocessor_move_to_instruction_in && sel_in == `CTIMC_SEL_IDX
				&& int'(pe_in) == g;
			ctimc_selector i_ctimc_selector (
				.core_clk_in(core_clk_in),
				.rst_in(rst_in),
				.wr_en_in(sel_wr[g]),
				.wr_data_in(wr_data_in),
				.probe_done_in(probe_done_in[g]),
				.probe_hit_in(probe_hit_in[g]),
				.probe_entry_in(probe_entry_in[g*`CTIMC_ENTRY_W +: `CTIMC_ENTRY_W]),
				.rd_data_out(sel_rd[g]),
				.probe_fail_out(sel_fail[g]),
				.entry_out(sel_entry[g])
			);
			// Valid selector of another sharing element blocks the random slot
			assign sel_hit[g] = st.shared_tlb_bit && pe_uses_tlb_in[g] && !sel_fail[g]
				&& sel_entry[g] == random_cand_in
				&& int'(random_pe_in) != g;
			// Shared bit only touches TLB-based elements
			assign shared_tlb_pe_out[g] = st.shared_tlb_bit && pe_uses_tlb_in[g];
			// No allocatable pairs, so hardware keeps the size fields right
			assign tlb_size_field_out[g*`CTIMC_SIZE_W +: `CTIMC_SIZE_W] =
				(st.shared_tlb_bit && pe_uses_tlb_in[g]) ? `CTIMC_SHARED_SIZE
				: `CTIMC_PER_PE_SIZE;
		end
	endgenerate

	assign ctrl_wr = coprocessor_move_to_instruction_in && sel_in == `CTIMC_SEL_CTRL;
	// Upper bits of the control word are constant zero
	assign ctrl_word = {28'h0000000, st.cache_partition_active, st.shared_tlb_bit, st.configuration_state_bit, st.virtual_processor_enable};

	// Control register update; master privilege gates every control move, not the enable and disable instructions
	always_comb begin
		next_st = st;
		if (ctrl_wr && master_privilege_bit_in) begin
			next_st.cache_partition_active = wr_data_in[`CTIMC_CPA_BIT];
			next_st.configuration_state_bit = wr_data_in[`CTIMC_VPC_BIT];
			next_st.virtual_processor_enable = wr_data_in[`CTIMC_EVP_BIT];
			// Old configuration state decides, not the value written alongside
			if (st.configuration_state_bit) begin
				next_st.shared_tlb_bit = wr_data_in[`CTIMC_SHARED_TLB_BIT_BIT];
			end
		end
		// Enable instructions override a move in the same cycle
		if (enable_elements_instruction_in) begin
			next_st.virtual_processor_enable = 1'b1;
		end else if (disable_elements_instruction_in) begin
			next_st.virtual_processor_enable = 1'b0;
		end
		// Remember which thread dropped the enable; only it keeps issuing
		if (st.virtual_processor_enable && !next_st.virtual_processor_enable) begin
			next_st.sole_tc = issuing_tc_in;
		end
		// Read path registered; write-only fields do not exist here
		unique case (rd_sel_in)
			`CTIMC_SEL_IDX: next_st.rd_data = sel_rd[rd_pe_in];
			`CTIMC_SEL_CTRL: next_st.rd_data = ctrl_word;
			default: next_st.rd_data = 32'h00000000;
		endcase
		next_st.skip = |sel_hit;
	end

	// All control bits clear at reset; context 0 is the only runner
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			st <= '{cache_partition_active: 1'b0, shared_tlb_bit: 1'b0, configuration_state_bit: 1'b0, virtual_processor_enable: 1'b0,
				sole_tc: `CTIMC_RESET_TC, rd_data: 32'h00000000, skip: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	assign rd_data_out = st.rd_data;
	// Skip is registered: the random generator sees it one cycle after its candidate
	assign random_skip_out = st.skip;
	assign cache_partition_active_out = st.cache_partition_active;
	assign shared_tlb_bit_out = st.shared_tlb_bit;
	assign configuration_state_bit_out = st.configuration_state_bit;
	assign presets_writable_out = st.configuration_state_bit;
	assign virtual_processor_enable_out = st.virtual_processor_enable;
	assign scheduling_allowed_out = st.virtual_processor_enable;
	assign sole_tc_out = st.sole_tc;
	// Both set is undefined; reported as configuration, which is the safer mode
	assign run_mode_out = st.configuration_state_bit ? CTIMC_RUN_CONFIG
		: (st.virtual_processor_enable ? CTIMC_RUN_MULTI : CTIMC_RUN_SINGLE);
endmodule : ctimc_top

// File: ctimc_monitor.sv
// Port checker for the selector and control block.
// Assumes one clock; bound to ctimc_top below.
`timescale 1ns/1ns
`include "ctimc_map.svh"
module ctimc_monitor
	import ctimc_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic coprocessor_move_to_instruction_in,
	input wire logic [2:0] sel_in,
	input wire logic [31:0] wr_data_in,
	input wire logic master_privilege_bit_in,
	input wire logic [2:0] rd_sel_in,
	input wire logic enable_elements_instruction_in,
	input wire logic disable_elements_instruction_in,
	input wire logic [`CTIMC_NUM_PE-1:0] pe_uses_tlb_in,
	input wire logic [31:0] rd_data_out,
	input wire logic cache_partition_active_out,
	input wire logic shared_tlb_bit_out,
	input wire logic configuration_state_bit_out,
	input wire logic virtual_processor_enable_out,
	input wire logic scheduling_allowed_out,
	input wire logic [`CTIMC_NUM_PE*`CTIMC_SIZE_W-1:0] tlb_size_field_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	// Control move alone; instructions in the same cycle win
	wire logic cmv = coprocessor_move_to_instruction_in && sel_in == 3'h1 && !enable_elements_instruction_in
		&& !disable_elements_instruction_in;
	priv_write_a: assert property (cmv && master_privilege_bit_in |=>
		cache_partition_active_out == $past(wr_data_in[3])
		&& configuration_state_bit_out == $past(wr_data_in[1])) else $error("control write lost");
	no_priv_a: assert property (cmv && !master_privilege_bit_in |=>
		$stable(cache_partition_active_out) && $stable(configuration_state_bit_out)
		&& $stable(shared_tlb_bit_out)) else $error("control write taken without privilege");
	shared_gate_a: assert property (cmv && !configuration_state_bit_out |=>
		$stable(shared_tlb_bit_out)) else $error("shared bit changed outside configuration");
	shared_set_a: assert property (cmv && master_privilege_bit_in && configuration_state_bit_out
		|=> shared_tlb_bit_out == $past(wr_data_in[2])) else $error("shared bit not written");
	en_instr_a: assert property (enable_elements_instruction_in |=>
		virtual_processor_enable_out) else $error("enable instruction ignored");
	dis_instr_a: assert property (disable_elements_instruction_in
		&& !enable_elements_instruction_in |=> !virtual_processor_enable_out)
		else $error("disable instruction ignored");
	sched_gate_a: assert property (scheduling_allowed_out == virtual_processor_enable_out)
		else $error("scheduling while enable clear");
	size_report_a: assert property (tlb_size_field_out[5:0] ==
		((shared_tlb_bit_out && pe_uses_tlb_in[0]) ? 6'h1F : 6'h0F)) else $error("size field wrong");
	ctrl_zero_a: assert property ($past(rd_sel_in) == 3'h1 |-> rd_data_out[31:4] == 28'h0)
		else $error("control upper bits not zero");
	sel_zero_a: assert property ($past(rd_sel_in) == 3'h0 |-> rd_data_out[30:6] == 25'h0)
		else $error("selector middle bits not zero");
endmodule : ctimc_monitor
bind ctimc_top ctimc_monitor i_ctimc_monitor (.*);

// File: test_cp0_tlb_index_mt_control.sv
// Directed bench for the selector and control block.
// Assumes ctimc_top with the map's two elements; inputs move on falling edges.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
	$display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module test_cp0_tlb_index_mt_control
	import ctimc_pkg::*;
;
	int n_errors = 0;
	int n_compared = 0;
	logic core_clk_in = '0, rst_in = 1'h1, coprocessor_move_to_instruction_in = '0, master_privilege_bit_in = '0;
	logic enable_elements_instruction_in = '0, disable_elements_instruction_in = '0;
	logic [2:0] sel_in = '0, rd_sel_in = '0;
	logic pe_in = '0, rd_pe_in = '0, random_pe_in = '0;
	logic [31:0] wr_data_in = '0, rd_data_out;
	logic [3:0] issuing_tc_in = '0, sole_tc_out;
	logic [1:0] probe_done_in = '0, probe_hit_in = '0, pe_uses_tlb_in = '0, shared_tlb_pe_out;
	logic [11:0] probe_entry_in = '0, tlb_size_field_out;
	logic [5:0] random_cand_in = '0;
	logic cache_partition_active_out, shared_tlb_bit_out, configuration_state_bit_out;
	logic virtual_processor_enable_out, random_skip_out, scheduling_allowed_out;
	logic presets_writable_out;
	ctimc_run_t run_mode_out;
	ctimc_top i_ctimc_top (.*);
	// Free-running core clock
	initial begin
		forever #2 core_clk_in = ~core_clk_in;
	end
	// One move, strobe held for exactly one edge
	task automatic mv(input logic [2:0] s, input logic p, input logic [31:0] d, input logic v);
		@(negedge core_clk_in);
		{coprocessor_move_to_instruction_in, sel_in, pe_in, wr_data_in, master_privilege_bit_in} = {1'h1, s, p, d, v};
		@(negedge core_clk_in);
		coprocessor_move_to_instruction_in = 1'h0;
	endtask : mv
	// Registered read, seen one edge after the select
	task automatic rd(input logic [2:0] s, input logic p, input logic [31:0] e);
		@(negedge core_clk_in);
		{rd_sel_in, rd_pe_in} = {s, p};
		@(negedge core_clk_in);
		`CHK("read", e, rd_data_out)
	endtask : rd
	// Random-write candidate from element 1
	task automatic cand(input logic [5:0] c, input logic e);
		@(negedge core_clk_in);
		{random_cand_in, random_pe_in} = {c, 1'h1};
		@(negedge core_clk_in);
		`CHK("skip", e, random_skip_out)
	endtask : cand
	// One probe result on element 0
	task automatic probe(input logic hit, input logic [5:0] ent);
		@(negedge core_clk_in);
		{probe_done_in, probe_hit_in, probe_entry_in} = {2'h1, 1'h0, hit, 6'h00, ent};
		@(negedge core_clk_in);
		probe_done_in = 2'h0;
	endtask : probe
	task automatic t_reset;
		rd(3'h1, 1'h0, 32'h0);
		rd(3'h5, 1'h0, 32'h0);
		`CHK("size", 12'h3CF, tlb_size_field_out)
		`CHK("mode", CTIMC_RUN_SINGLE, run_mode_out)
	endtask : t_reset
	task automatic t_sel;
		probe(1'h0, 6'h00);
		rd(3'h0, 1'h0, 32'h8000_0000);
		probe(1'h1, 6'h09);
		rd(3'h0, 1'h0, 32'h0000_0009);
		mv(3'h0, 1'h1, 32'h8000_0015, 1'h0);
		rd(3'h0, 1'h1, 32'h8000_0015);
	endtask : t_sel
	task automatic t_ctrl;
		pe_uses_tlb_in = 2'h1;
		mv(3'h1, 1'h0, 32'hF, 1'h0);
		rd(3'h1, 1'h0, 32'h0);
		mv(3'h1, 1'h0, 32'h6, 1'h1);
		rd(3'h1, 1'h0, 32'h2);
		`CHK("pre", 1'h1, presets_writable_out)
		mv(3'h1, 1'h0, 32'hE, 1'h1);
		rd(3'h1, 1'h0, 32'hE);
		`CHK("shared_tlb_bit", 1'h1, shared_tlb_bit_out)
		`CHK("cpa", 1'h1, cache_partition_active_out)
		`CHK("share", 2'h1, shared_tlb_pe_out)
		`CHK("size", 12'h3DF, tlb_size_field_out)
	endtask : t_ctrl
	task automatic t_skip;
		pe_uses_tlb_in = 2'h3;
		mv(3'h0, 1'h0, 32'h5, 1'h0);
		cand(6'h05, 1'h1);
		cand(6'h06, 1'h0);
		mv(3'h0, 1'h0, 32'h8000_0005, 1'h0);
		cand(6'h05, 1'h0);
		mv(3'h1, 1'h0, 32'h0, 1'h1);
		rd(3'h1, 1'h0, 32'h0);
	endtask : t_skip
	task automatic t_en;
		@(negedge core_clk_in);
		enable_elements_instruction_in = 1'h1;
		@(negedge core_clk_in);
		enable_elements_instruction_in = 1'h0;
		`CHK("mode", CTIMC_RUN_MULTI, run_mode_out)
		`CHK("sched", 1'h1, scheduling_allowed_out)
		{issuing_tc_in, disable_elements_instruction_in} = {4'h3, 1'h1};
		@(negedge core_clk_in);
		disable_elements_instruction_in = 1'h0;
		// Barrier slot before trusting the others are quiet
		@(negedge core_clk_in);
		`CHK("enable", 1'h0, virtual_processor_enable_out)
		`CHK("sched", 1'h0, scheduling_allowed_out)
		`CHK("sole", 4'h3, sole_tc_out)
	endtask : t_en
	// Mid-run reset drops every bit and hands the core back to context 0
	task automatic t_rst;
		mv(3'h1, 1'h0, 32'h2, 1'h1);
		@(negedge core_clk_in);
		`CHK("cfg", 1'h1, configuration_state_bit_out)
		`CHK("mode", CTIMC_RUN_CONFIG, run_mode_out)
		rst_in = 1'h1;
		@(negedge core_clk_in);
		`CHK("cfg", 1'h0, configuration_state_bit_out)
		`CHK("sole", 4'h0, sole_tc_out)
		rst_in = 1'h0;
		rd(3'h0, 1'h1, 32'h0);
		rd(3'h1, 1'h0, 32'h0);
	endtask : t_rst
	task automatic final_report;
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : final_report
	// Reset for six cycles, then every scenario once
	initial begin
		repeat (6) @(negedge core_clk_in);
		rst_in = 1'h0;
		t_reset;
		t_sel;
		t_ctrl;
		t_skip;
		t_en;
		t_rst;
		final_report;
	end
endmodule : test_cp0_tlb_index_mt_control
